// ===== shifter_regs.vh
`ifndef SHIFTER_REGS_VH
`define SHIFTER_REGS_VH

// widths
`define SHIFTER_DATA_W        8
`define SHIFTER_CNT_W         4

// reset values
`define SHIFTER_DATA_RST      8'h00
`define SHIFTER_CNT_RST       4'h0
`define SHIFTER_CNT_MAX       4'hF
`define SHIFTER_PIN_IDLE      1'b1

// wire mode select
`define SHIFTER_WM_OFF        2'b00
`define SHIFTER_WM_THREE      2'b01
`define SHIFTER_WM_TWO        2'b10
`define SHIFTER_WM_TWO_HOLD   2'b11

// clock source select
`define SHIFTER_CS_SOFT       2'b00
`define SHIFTER_CS_TIMER      2'b01
`define SHIFTER_CS_EXT        2'b10
`define SHIFTER_CS_EXT_ALT    2'b11

// serial clock limits as system clock divisors
`define SHIFTER_TW_DIV        16
`define SHIFTER_3W_MST_DIV    2
`define SHIFTER_3W_SLV_DIV    4

// least half period in system clocks, derived from the divisors
`define SHIFTER_TW_HALF       (`SHIFTER_TW_DIV / 2)
`define SHIFTER_3W_MST_HALF   (`SHIFTER_3W_MST_DIV / 2)
`define SHIFTER_3W_SLV_HALF   (`SHIFTER_3W_SLV_DIV / 2)
`define SHIFTER_GAP_W         5

`endif

// ===== sync_filter.v
`timescale 1ns/1ps
`default_nettype none

module sync_filter #(
  parameter RESET_LEVEL = 1'b1
) (
  // clock and reset
  input  wire clk,
  input  wire sys_rst,
  // pin side
  input  wire pin_in,
  // filtered side
  output reg  level,
  output reg  rise,
  output reg  fall
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // s1_r feeds only s2_r; a change is accepted once s2_r and s3_r agree
  always @(posedge clk) begin
    if (sys_rst) begin
      s1_r  <= RESET_LEVEL;
      s2_r  <= RESET_LEVEL;
      s3_r  <= RESET_LEVEL;
      level <= RESET_LEVEL;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      rise <= 1'b0;
      fall <= 1'b0;
      if (s2_r == s3_r && s3_r != level) begin
        level <= s3_r;
        rise  <= s3_r;
        fall  <= ~s3_r;
      end
    end
  end

endmodule // sync_filter

`default_nettype wire

// ===== start_detect.v
`timescale 1ns/1ps
`default_nettype none

module start_detect (
  // clock and reset
  input  wire clk,
  input  wire sys_rst,
  // filtered bus lines
  input  wire enable,
  input  wire scl_level,
  input  wire sda_fall,
  // detection
  output reg  start_pulse
);

  // a start is the data line falling while the clock line is high
  always @(posedge clk) begin
    if (sys_rst) begin
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= enable & scl_level & sda_fall;
    end
  end

endmodule // start_detect

`default_nettype wire

// ===== universal_serial_shifter.v
`timescale 1ns/1ps
`default_nettype none
`include "shifter_regs.vh"

// What this block does
// - two-wire serial clock stays at or below one sixteenth of system clock.
// - three-wire clock up to half system clock as master, quarter as slave.
// - one 8-bit shift register, read and written directly, no receive buffer.
// - register MSB goes to the data-out pin or the two-wire data pin.
// - with external clock a latch holds the outgoing bit until the edge opposite sampling.
// - serial input is always taken from the data-input pin.
// - 4-bit counter, readable and writable, raises overflow request on wrap.
// - shift register and counter advance from the same clock source.
// - with external clock the counter counts both edges.
// - clock comes from the clock pin, timer zero overflow or software strobe.
// - two-wire mode detects a start condition and can request an interrupt.
// - two-wire mode holds clock low after start, and in hold mode also after counter overflow.
// - three-wire mode is SPI modes 0 and 1, no slave select.
// - eight serial clocks exchange the contents of two ringed registers.
// - an overflow flag marks transfer completion and can interrupt.
// - wakes from idle; in two-wire mode a start wakes from every sleep mode.
// - edge select 0 samples on rising, shifts out on falling; 1 swaps.
// - from zero, eight clock pulses (sixteen edges) overflow the counter.
module universal_serial_shifter #(
  parameter DATA_W = `SHIFTER_DATA_W,
  parameter CNT_W  = `SHIFTER_CNT_W
) (
  // clock and reset
  input  wire              clk,
  input  wire              sys_rst,
  // configuration
  input  wire [1:0]        wire_mode,
  input  wire [1:0]        clk_source,
  input  wire              external_edge_select,
  input  wire              master_mode,
  input  wire              start_int_en,
  input  wire              ovf_int_en,
  // software strobes
  input  wire              software_clock_strobe,
  input  wire              clock_toggle_strobe,
  input  wire              timer_zero_overflow,
  // shift data register access
  input  wire [DATA_W-1:0] data_wdata,
  input  wire              data_we,
  output reg  [DATA_W-1:0] shift_data_register,
  // counter access
  input  wire [CNT_W-1:0]  cnt_wdata,
  input  wire              cnt_we,
  output reg  [CNT_W-1:0]  bit_counter,
  // status flags and their clears
  output reg               ovf_flag,
  input  wire              ovf_clear,
  output reg               start_flag,
  input  wire              start_clear,
  output reg               rate_error,
  input  wire              rate_clear,
  // interrupt and wake requests
  output reg               ovf_irq,
  output reg               start_irq,
  output reg               wake_idle,
  output reg               wake_any_sleep,
  // port direction controls for the pins
  input  wire              data_out_drive,
  input  wire              clock_pin_drive,
  // serial pins
  input  wire              serial_data_input_pin,
  output reg               data_out_pin,
  input  wire              shifter_clock_pin,
  output reg               shifter_clock_out,
  output reg               shifter_clock_oe_n,
  output reg               sda_out,
  output reg               sda_oe_n
);

  wire              ck_level;
  wire              ck_rise;
  wire              ck_fall;
  wire              di_level;
  wire              di_rise;
  wire              di_fall;
  wire              start_pulse;

  wire              three_wire;
  wire              two_wire;
  wire              ext_sel;
  wire              int_tick;
  wire              sample_edge;
  wire              cnt_tick;
  wire              latch_open;
  wire              wrap;
  wire [`SHIFTER_GAP_W-1:0] min_half;

  reg  [DATA_W-1:0] data_nxt;
  reg  [CNT_W-1:0]  cnt_nxt;
  reg               out_latch_r;
  reg               clk_out_r;
  reg  [`SHIFTER_GAP_W-1:0] gap_r;
  reg               hold_low;

  // pin synchronisers, same depth so clock and data stay aligned
  sync_filter #(
    .RESET_LEVEL (`SHIFTER_PIN_IDLE)
  ) u_clk_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  (shifter_clock_pin),
    .level   (ck_level),
    .rise    (ck_rise),
    .fall    (ck_fall)
  );

  sync_filter #(
    .RESET_LEVEL (`SHIFTER_PIN_IDLE)
  ) u_data_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_in  (serial_data_input_pin),
    .level   (di_level),
    .rise    (di_rise),
    .fall    (di_fall)
  );

  start_detect u_start (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .enable      (two_wire),
    .scl_level   (ck_level),
    .sda_fall    (di_fall),
    .start_pulse (start_pulse)
  );

  assign three_wire = (wire_mode == `SHIFTER_WM_THREE);
  assign two_wire   = wire_mode[1];
  assign ext_sel    = clk_source[1];

  // internal sources tick once per event
  assign int_tick = (clk_source == `SHIFTER_CS_TIMER) ? timer_zero_overflow :
                    software_clock_strobe;

  // sampling edge follows the edge select for the external source
  assign sample_edge = ext_sel ?
                       (external_edge_select ? ck_fall : ck_rise) :
                       int_tick;

  // counter sees both external edges, so one bit is two counts
  assign cnt_tick = ext_sel ? (ck_rise | ck_fall) : int_tick;

  assign wrap = cnt_tick & (bit_counter == `SHIFTER_CNT_MAX);

  // latch is open in the clock phase before the sampling edge
  assign latch_open = ext_sel ? (ck_level == external_edge_select) : 1'b1;

  // shift data register: a write wins over a shift in the same cycle
  always @* begin
    data_nxt = shift_data_register;
    if (data_we) begin
      data_nxt = data_wdata;
    end else if (sample_edge) begin
      data_nxt = {shift_data_register[DATA_W-2:0], di_level};
    end
  end

  // counter: a write wins over a tick; it wraps naturally at four bits
  always @* begin
    cnt_nxt = bit_counter;
    if (cnt_we) begin
      cnt_nxt = cnt_wdata;
    end else if (cnt_tick) begin
      cnt_nxt = bit_counter + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      shift_data_register <= `SHIFTER_DATA_RST;
      bit_counter         <= `SHIFTER_CNT_RST;
    end else begin
      shift_data_register <= data_nxt;
      bit_counter         <= cnt_nxt;
    end
  end

  // output latch, follows the register msb only while open
  always @(posedge clk) begin
    if (sys_rst) begin
      out_latch_r <= 1'b0;
    end else if (latch_open) begin
      out_latch_r <= shift_data_register[DATA_W-1];
    end
  end

  // flags: a setting event wins over a clear in the same cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      ovf_flag   <= 1'b0;
      start_flag <= 1'b0;
    end else begin
      if (wrap) begin
        ovf_flag <= 1'b1;
      end else if (ovf_clear) begin
        ovf_flag <= 1'b0;
      end
      if (start_pulse) begin
        start_flag <= 1'b1;
      end else if (start_clear) begin
        start_flag <= 1'b0;
      end
    end
  end

  // least half periods, cut to the gap counter width on purpose;
  // the counter saturates, so a slow or idle clock never reads as too fast
  localparam [31:0] TW_HALF_I  = `SHIFTER_TW_HALF;
  localparam [31:0] MST_HALF_I = `SHIFTER_3W_MST_HALF;
  localparam [31:0] SLV_HALF_I = `SHIFTER_3W_SLV_HALF;
  localparam [`SHIFTER_GAP_W-1:0] TW_HALF  = TW_HALF_I[`SHIFTER_GAP_W-1:0];
  localparam [`SHIFTER_GAP_W-1:0] MST_HALF = MST_HALF_I[`SHIFTER_GAP_W-1:0];
  localparam [`SHIFTER_GAP_W-1:0] SLV_HALF = SLV_HALF_I[`SHIFTER_GAP_W-1:0];
  localparam [`SHIFTER_GAP_W-1:0] GAP_ONE  = {{(`SHIFTER_GAP_W-1){1'b0}}, 1'b1};

  // serial clock rate watch; master three-wire needs only one cycle per half
  assign min_half = two_wire ? TW_HALF :
                    (master_mode ? MST_HALF : SLV_HALF);

  always @(posedge clk) begin
    if (sys_rst) begin
      gap_r      <= {`SHIFTER_GAP_W{1'b1}};
      rate_error <= 1'b0;
    end else begin
      if (ck_rise | ck_fall) begin
        gap_r <= {`SHIFTER_GAP_W{1'b0}};
      end else if (gap_r != {`SHIFTER_GAP_W{1'b1}}) begin
        gap_r <= gap_r + {{(`SHIFTER_GAP_W-1){1'b0}}, 1'b1};
      end
      // gap_r counts idle cycles, so the half period is gap_r plus one
      if (ext_sel && wire_mode != `SHIFTER_WM_OFF &&
          (ck_rise | ck_fall) && gap_r < min_half - GAP_ONE) begin
        rate_error <= 1'b1;
      end else if (rate_clear) begin
        rate_error <= 1'b0;
      end
    end
  end

  // wait states: clock held low while start is pending, or overflow in hold mode
  always @* begin
    hold_low = 1'b0;
    if (two_wire) begin
      hold_low = start_flag |
                 (ovf_flag & (wire_mode == `SHIFTER_WM_TWO_HOLD));
    end
  end

  // master clock output; the toggle strobe flips the driven level
  always @(posedge clk) begin
    if (sys_rst) begin
      clk_out_r <= `SHIFTER_PIN_IDLE;
    end else if (clock_toggle_strobe) begin
      clk_out_r <= ~clk_out_r;
    end
  end

  // pins and requests are registered so they change only on clock edges
  always @(posedge clk) begin
    if (sys_rst) begin
      data_out_pin       <= 1'b0;
      shifter_clock_out  <= `SHIFTER_PIN_IDLE;
      shifter_clock_oe_n <= 1'b1;
      sda_out            <= 1'b0;
      sda_oe_n           <= 1'b1;
      ovf_irq            <= 1'b0;
      start_irq          <= 1'b0;
      wake_idle          <= 1'b0;
      wake_any_sleep     <= 1'b0;
    end else begin
      // msb goes to data-out in three-wire mode, to the data line in two-wire mode
      data_out_pin <= three_wire ? out_latch_r : 1'b0;
      sda_out      <= 1'b0;
      sda_oe_n     <= ~(two_wire & data_out_drive & ~out_latch_r);
      if (two_wire) begin
        // open drain: only ever pulls low
        shifter_clock_out  <= 1'b0;
        shifter_clock_oe_n <= ~(hold_low | (clock_pin_drive & ~clk_out_r));
      end else begin
        shifter_clock_out  <= clk_out_r;
        shifter_clock_oe_n <= ~(three_wire & clock_pin_drive);
      end
      ovf_irq        <= ovf_flag & ovf_int_en;
      start_irq      <= start_flag & start_int_en;
      wake_idle      <= (ovf_flag & ovf_int_en) | (start_flag & start_int_en);
      wake_any_sleep <= two_wire & start_flag & start_int_en;
    end
  end

  // data output is for the other party's sampling; di rise is not used here
  wire unused_ok = di_rise;

endmodule // universal_serial_shifter

`default_nettype wire

// ===== shifter_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_peer (
  // control
  input  wire logic       go,
  input  wire logic       cpha,
  input  wire logic [7:0] tx_byte,
  // serial lines
  input  wire logic       miso,
  output var  logic       sck,
  output var  logic       mosi,
  // result
  output var  logic [7:0] rx_byte,
  output var  logic       done
);
  logic [7:0] sh_r;
  initial {sck, mosi, rx_byte, done} = '0;
  // clock idles low between frames; 80 ns half period keeps within the slave limit
  always @(posedge go) begin
    sh_r = tx_byte;
    done = 1'b0;
    mosi = sh_r[7];
    for (int i = 0; i < 8; i++) begin
      #80 sck = 1'b1;
      if (cpha) mosi = sh_r[7];
      else sh_r = {sh_r[6:0], miso};
      #80 sck = 1'b0;
      if (cpha) sh_r = {sh_r[6:0], miso};
      else mosi = sh_r[7];
    end
    // the last bit has been taken by now, so stop showing it
    #80 mosi = ~mosi;
    rx_byte = sh_r;
    done = 1'b1;
  end
endmodule // spi_master_peer
`default_nettype wire

// ===== universal_serial_shifter_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "shifter_regs.vh"
module shifter_checker #(
  parameter int DATA_W = 8,
  parameter int CNT_W  = 4
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // controls
  input wire logic [1:0]        wire_mode,
  input wire logic [1:0]        clk_source,
  input wire logic              software_clock_strobe,
  input wire logic              timer_zero_overflow,
  input wire logic              data_we,
  input wire logic              cnt_we,
  input wire logic              ovf_clear,
  input wire logic              shifter_clock_pin,
  // state and pins
  input wire logic [DATA_W-1:0] shift_data_register,
  input wire logic [CNT_W-1:0]  bit_counter,
  input wire logic              ovf_flag,
  input wire logic              start_flag,
  input wire logic              data_out_pin,
  input wire logic              shifter_clock_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // a write in the same cycle swallows the tick, so those are left out
  wire tick = clk_source == `SHIFTER_CS_SOFT && software_clock_strobe && !data_we && !cnt_we;
  property p_cnt; tick |=> bit_counter == $past(bit_counter) + 1'b1; endproperty
  a_cnt: assert property (p_cnt) else $error("count step");
  property p_shf;
    tick |=> shift_data_register[DATA_W-1:1] == $past(shift_data_register[DATA_W-2:0]);
  endproperty
  a_shf: assert property (p_shf) else $error("shift step");
  property p_wrap; tick && bit_counter == `SHIFTER_CNT_MAX |=> ovf_flag && bit_counter == 0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap");
  property p_hold; ovf_flag && !ovf_clear |=> ovf_flag; endproperty
  a_hold: assert property (p_hold) else $error("ovf lost");
  property p_sel;
    clk_source == `SHIFTER_CS_SOFT && timer_zero_overflow && !software_clock_strobe && !cnt_we
      |=> $stable(bit_counter);
  endproperty
  a_sel: assert property (p_sel) else $error("unselected source");
  property p_off; (wire_mode != `SHIFTER_WM_THREE) [*2] |-> !data_out_pin; endproperty
  a_off: assert property (p_off) else $error("data out");
  property p_low; (wire_mode[1] && start_flag) [*2] |-> !shifter_clock_oe_n; endproperty
  a_low: assert property (p_low) else $error("clock not held");
  property p_edge;
    clk_source[1] && $rose(shifter_clock_pin) && !cnt_we |-> ##[2:6] $changed(bit_counter);
  endproperty
  a_edge: assert property (p_edge) else $error("edge not counted");
  c_wrap: cover property (tick && bit_counter == `SHIFTER_CNT_MAX);
  c_start: cover property ($rose(start_flag));
  c_edge: cover property (clk_source[1] && $rose(shifter_clock_pin));
endmodule // shifter_checker
bind universal_serial_shifter shifter_checker #(.DATA_W(DATA_W), .CNT_W(CNT_W)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .wire_mode(wire_mode), .clk_source(clk_source),
  .software_clock_strobe(software_clock_strobe), .timer_zero_overflow(timer_zero_overflow),
  .data_we(data_we), .cnt_we(cnt_we), .ovf_clear(ovf_clear),
  .shifter_clock_pin(shifter_clock_pin), .shift_data_register(shift_data_register),
  .bit_counter(bit_counter), .ovf_flag(ovf_flag), .start_flag(start_flag),
  .data_out_pin(data_out_pin), .shifter_clock_oe_n(shifter_clock_oe_n));
`default_nettype wire

// ===== universal_serial_shifter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "shifter_regs.vh"
module universal_serial_shifter_tb_top;
  logic       clk, sys_rst, external_edge_select, master_mode, start_int_en, ovf_int_en;
  logic       software_clock_strobe, clock_toggle_strobe, timer_zero_overflow, data_we;
  logic       cnt_we, ovf_clear, start_clear, rate_clear, data_out_drive, clock_pin_drive;
  logic       own, go, sck_b, di_b;
  logic [1:0] wire_mode, clk_source;
  logic [7:0] data_wdata;
  logic [3:0] cnt_wdata;
  wire  [7:0] shift_data_register, rx_byte;
  wire  [3:0] bit_counter;
  wire        ovf_flag, start_flag, rate_error, ovf_irq, start_irq, wake_idle, wake_any_sleep;
  wire        data_out_pin, shifter_clock_out, shifter_clock_oe_n, sda_out, sda_oe_n;
  wire        sck_m, mosi_m, done, scl_w, di_w;
  int         n_mismatch, checked, cycles;
  // pulled-up lines: any party driving low wins
  assign scl_w = (own ? sck_m : sck_b) & (shifter_clock_oe_n | shifter_clock_out);
  assign di_w = (own ? mosi_m : di_b) & (sda_oe_n | sda_out);
  universal_serial_shifter dut_u (
    .clk(clk), .sys_rst(sys_rst), .wire_mode(wire_mode), .clk_source(clk_source),
    .external_edge_select(external_edge_select), .master_mode(master_mode),
    .start_int_en(start_int_en), .ovf_int_en(ovf_int_en),
    .software_clock_strobe(software_clock_strobe), .clock_toggle_strobe(clock_toggle_strobe),
    .timer_zero_overflow(timer_zero_overflow), .data_wdata(data_wdata), .data_we(data_we),
    .shift_data_register(shift_data_register), .cnt_wdata(cnt_wdata), .cnt_we(cnt_we),
    .bit_counter(bit_counter), .ovf_flag(ovf_flag), .ovf_clear(ovf_clear),
    .start_flag(start_flag), .start_clear(start_clear), .rate_error(rate_error),
    .rate_clear(rate_clear), .ovf_irq(ovf_irq), .start_irq(start_irq), .wake_idle(wake_idle),
    .wake_any_sleep(wake_any_sleep), .data_out_drive(data_out_drive),
    .clock_pin_drive(clock_pin_drive), .serial_data_input_pin(di_w),
    .data_out_pin(data_out_pin), .shifter_clock_pin(scl_w),
    .shifter_clock_out(shifter_clock_out), .shifter_clock_oe_n(shifter_clock_oe_n),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  spi_master_peer peer_u (.go(go), .cpha(external_edge_select), .tx_byte(8'h5A),
                          .miso(data_out_pin), .sck(sck_m),
                          .mosi(mosi_m), .rx_byte(rx_byte), .done(done));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task print_verdict;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task tick(input int n);
    repeat (n) begin
      @(negedge clk) software_clock_strobe = 1'b1;
      @(negedge clk) software_clock_strobe = 1'b0;
    end
  endtask
  task tmr;
    @(negedge clk) timer_zero_overflow = 1'b1;
    @(negedge clk) timer_zero_overflow = 1'b0;
  endtask
  task clear;
    @(negedge clk) {ovf_clear, start_clear, rate_clear} = 3'h7;
    @(negedge clk) {ovf_clear, start_clear, rate_clear} = 3'h0;
  endtask
  task wr(input logic [7:0] d);
    @(negedge clk) {data_wdata, cnt_wdata, data_we, cnt_we} = {d, 4'h0, 2'h3};
    @(negedge clk) {data_we, cnt_we} = 2'h0;
  endtask
  task t_reset;
    chk("data", 8'h00, shift_data_register);
    chk("count", 8'h00, bit_counter);
    chk("clock_oe_n", 8'h01, shifter_clock_oe_n);
    @(negedge clk) clock_toggle_strobe = 1'b1;
    @(negedge clk) clock_toggle_strobe = 1'b0;
    cyc(1);
    chk("clock_out", 8'h00, shifter_clock_out);
    $display("reset test done");
  endtask
  task t_soft;
    wr(8'hA5);
    tmr;
    chk("count_unsel", 8'h00, bit_counter);
    tick(15);
    chk("count_15", 8'h0F, bit_counter);
    chk("ovf_early", 8'h00, ovf_flag);
    tick(1);
    chk("count_wrap", 8'h00, bit_counter);
    chk("ovf", 8'h01, ovf_flag);
    chk("data_fill", 8'hFF, shift_data_register);
    cyc(1);
    chk("ovf_irq", 8'h01, ovf_irq);
    chk("wake_idle", 8'h01, wake_idle);
    chk("ovf_sticky", 8'h01, ovf_flag);
    clear;
    clk_source = `SHIFTER_CS_TIMER;
    tmr;
    chk("count_timer", 8'h01, bit_counter);
    $display("soft clock test done");
  endtask
  task t_spi(input logic edge_sel);
    wire_mode = `SHIFTER_WM_THREE;
    clk_source = `SHIFTER_CS_SOFT;
    external_edge_select = edge_sel;
    // hand the clock line to the peer while no external edge is counted
    own = 1'b1;
    cyc(6);
    wr(8'hC3);
    clear;
    clk_source = `SHIFTER_CS_EXT;
    cyc(4);
    go = 1'b1;
    cyc(1);
    for (int i = 0; i < 400 && !done; i++) @(negedge clk);
    cyc(8);
    chk("peer_rx", 8'hC3, rx_byte);
    chk("dut_rx", 8'h5A, shift_data_register);
    chk("edges", 8'h00, bit_counter);
    chk("ovf_end", 8'h01, ovf_flag);
    chk("rate", 8'h00, rate_error);
    go = 1'b0;
    $display("three-wire test done");
  endtask
  task t_start;
    clk_source = `SHIFTER_CS_SOFT;
    sck_b = 1'b1;
    own = 1'b0;
    // msb high first, so the block leaves the data line released
    wr(8'hFF);
    cyc(1);
    wire_mode = `SHIFTER_WM_TWO;
    clear;
    cyc(6);
    chk("sda_released", 8'h01, sda_oe_n);
    chk("sda_out", 8'h00, sda_out);
    di_b = 1'b0;
    cyc(8);
    chk("start", 8'h01, start_flag);
    chk("start_irq", 8'h01, start_irq);
    chk("wake_all", 8'h01, wake_any_sleep);
    chk("hold", 8'h00, shifter_clock_oe_n);
    di_b = 1'b1;
    clear;
    cyc(2);
    chk("release", 8'h01, shifter_clock_oe_n);
    wire_mode = `SHIFTER_WM_TWO_HOLD;
    tick(16);
    cyc(1);
    chk("hold_ovf", 8'h00, shifter_clock_oe_n);
    wr(8'h00);
    cyc(2);
    chk("sda_drive", 8'h00, sda_oe_n);
    $display("start test done");
  endtask
  initial begin
    {own, go, external_edge_select, master_mode, software_clock_strobe} = '0;
    {clock_toggle_strobe, timer_zero_overflow, data_we, cnt_we, ovf_clear} = '0;
    {start_clear, rate_clear, clock_pin_drive, cycles} = '0;
    {n_mismatch, checked, wire_mode, clk_source, data_wdata, cnt_wdata} = '0;
    // bus lines idle high, the level the pin synchronisers reset to
    {sys_rst, di_b, sck_b, start_int_en, ovf_int_en, data_out_drive} = 6'h3F;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_reset;
    t_soft;
    t_spi(1'b0);
    t_spi(1'b1);
    t_start;
    print_verdict;
  end
endmodule // universal_serial_shifter_tb_top
`default_nettype wire
